// ==== spihb_defines.vh ====
// Purpose: Constants for the serial slave and fault reporting block
// Assumes: 100 MHz core clock
// Notes: Register codes sit in command bits 14:13
`ifndef SPIHB_DEFINES_VH
`define SPIHB_DEFINES_VH

// ****************************************
// Frame layout
// ****************************************
`define SPIHB_WORD_BITS 16
`define SPIHB_RW_BIT 15
`define SPIHB_SEL_HI 14
`define SPIHB_SEL_LO 13

// ****************************************
// Register select codes
// ****************************************
`define SPIHB_SEL_ID 2'h0
`define SPIHB_SEL_STATUS 2'h1
`define SPIHB_SEL_MASK 2'h2
`define SPIHB_SEL_CONFIG 2'h3

// ****************************************
// Status field positions
// ****************************************
`define SPIHB_FAULT_BITS 11
`define SPIHB_FRAME_ERR_BIT 11

// ****************************************
// Reset values
// ****************************************
`define SPIHB_MASK_RST 13'h06f1
`define SPIHB_CONFIG_RST 13'h0d98
`define SPIHB_STATUS_RST 12'h000

// ****************************************
// Timing
// ****************************************
`define SPIHB_CLK_MHZ 100
`define SPIHB_CLR_PULSE_NS 1000
`define SPIHB_CLR_PULSE_CYC ((`SPIHB_CLR_PULSE_NS * `SPIHB_CLK_MHZ + 999) / 1000)

`endif

// ==== spihb_sync.v ====
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Inputs change slower than the core clock
// Notes: Only the second stage leaves this module
`timescale 1ns/1ps

module spihb_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire core_clk,
	input wire arst_n,
	// Levels
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_q <= {WIDTH{1'b0}};
			stage2_q <= {WIDTH{1'b0}};
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;
endmodule // spihb_sync

// ==== spihb_slave.v ====
// Purpose: 16-bit serial slave with latched fault status and clearing
// Assumes: Serial clock, select and pins sampled by core_clk (>= 8x sclk)
// Notes: Link pins are oversampled, not clocked, so sclk may stop freely
`timescale 1ns/1ps
`include "spihb_defines.vh"

module spihb_slave #(
	parameter [4:0] ID_CODE = 5'h00 // Arbitrary identity value
) (
	// Clock and reset
	input wire core_clk,
	input wire arst_n,
	// Serial link pins
	input wire csN,
	input wire sclk,
	input wire mosi,
	output reg miso,
	output reg misoOe,
	// Control pins
	input wire output_disable_in,
	input wire device_enable_in,
	// Fault sensing levels, high while a fault is present
	input wire [`SPIHB_FAULT_BITS-1:0] faultActive,
	// Register contents for the rest of the device
	output reg [`SPIHB_FAULT_BITS:0] statusOut,
	output reg [12:0] maskOut,
	output reg [12:0] configOut,
	output reg framing_error_flag
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam SYNC_W = 5 + `SPIHB_FAULT_BITS;
	wire [SYNC_W-1:0] syncIn;
	wire [SYNC_W-1:0] syncOut;
	wire csS;
	wire sclkS;
	wire mosiS;
	wire offS;
	wire enS;
	wire [`SPIHB_FAULT_BITS-1:0] faultS;

	// Select travels inverted: the all-zero sync reset then reads as idle, no false fall
	assign syncIn = {faultActive, device_enable_in, output_disable_in, mosi, sclk, ~csN};

	spihb_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	assign csS = ~syncOut[0];
	assign sclkS = syncOut[1];
	assign mosiS = syncOut[2];
	assign offS = syncOut[3];
	assign enS = syncOut[4];
	assign faultS = syncOut[SYNC_W-1:5];

	// ****************************************
	// Edge detection
	// ****************************************
	reg csPrev_q;
	reg sclkPrev_q;
	reg offPrev_q;
	reg enPrev_q;

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			csPrev_q <= 1'b1;
			sclkPrev_q <= 1'b0;
			offPrev_q <= 1'b0;
			enPrev_q <= 1'b0;
		end else begin
			csPrev_q <= csS;
			sclkPrev_q <= sclkS;
			offPrev_q <= offS;
			enPrev_q <= enS;
		end
	end

	wire csFall = csPrev_q & ~csS;
	wire csRise = ~csPrev_q & csS;
	wire sclkFall = ~csS & sclkPrev_q & ~sclkS;
	wire sclkRise = ~csS & ~sclkPrev_q & sclkS;
	wire offFall = offPrev_q & ~offS;
	wire enRise = ~enPrev_q & enS;
	// Clears act only on faults no longer present
	wire pinClear = offFall | enRise;

	// ****************************************
	// Shift path
	// ****************************************
	reg [15:0] shift_q;
	reg inBit_q;
	reg [3:0] clkCnt_q;
	reg anyClk_q;
	reg [1:0] sel_q;
	reg [15:0] respData;
	wire [15:0] rxWord = {shift_q[14:0], inBit_q};

	// Read-back words carry their select code in bits 14:13
	always @* begin
		case (sel_q)
		`SPIHB_SEL_ID: respData = {11'h000, ID_CODE};
		`SPIHB_SEL_STATUS: respData = {4'h2, statusOut};
		`SPIHB_SEL_MASK: respData = {3'h2, maskOut};
		`SPIHB_SEL_CONFIG: respData = {3'h3, configOut};
		default: respData = 16'h0000;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_q <= 16'h0000;
			inBit_q <= 1'b0;
			clkCnt_q <= 4'h0;
			anyClk_q <= 1'b0;
			miso <= 1'b0;
			misoOe <= 1'b0;
		end else begin
			misoOe <= ~csS;
			if (csFall) begin
				shift_q <= respData;
				miso <= respData[15];
				clkCnt_q <= 4'h0;
				anyClk_q <= 1'b0;
			end else begin
				if (sclkFall) begin
					inBit_q <= mosiS;
					clkCnt_q <= clkCnt_q + 4'h1;
					anyClk_q <= 1'b1;
				end
				if (sclkRise && anyClk_q) begin
					// Received bits follow the reply out, feeding the next device
					shift_q <= rxWord;
					miso <= shift_q[14];
				end
			end
		end
	end

	// ****************************************
	// Frame decode
	// ****************************************
	wire frameBad = ~anyClk_q | (clkCnt_q != 4'h0);
	wire isWrite = rxWord[`SPIHB_RW_BIT];
	wire [1:0] rxSel = rxWord[`SPIHB_SEL_HI:`SPIHB_SEL_LO];
	wire frameErr = csRise & (frameBad | (isWrite & (rxSel == `SPIHB_SEL_ID)));
	wire frameOk = csRise & ~frameErr;
	wire wrStatus = frameOk & isWrite & (rxSel == `SPIHB_SEL_STATUS);
	wire wrMask = frameOk & isWrite & (rxSel == `SPIHB_SEL_MASK);
	wire wrConfig = frameOk & isWrite & (rxSel == `SPIHB_SEL_CONFIG);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= `SPIHB_SEL_STATUS;
			maskOut <= `SPIHB_MASK_RST;
			configOut <= `SPIHB_CONFIG_RST;
		end else begin
			if (enRise) begin
				sel_q <= `SPIHB_SEL_STATUS;
			end else if (frameOk) begin
				sel_q <= rxSel;
			end
			if (wrMask) begin
				maskOut <= rxWord[12:0];
			end
			if (wrConfig) begin
				configOut <= rxWord[12:0];
			end
		end
	end

	// ****************************************
	// Fault status
	// ****************************************
	genvar i;
	wire [`SPIHB_FAULT_BITS:0] status_d;

	generate
		for (i = 0; i < `SPIHB_FAULT_BITS; i = i + 1) begin : gFault
			wire clrHere = (pinClear | (wrStatus & rxWord[i])) & ~faultS[i];
			// A present fault sets the bit even when a clear lands in the same cycle
			assign status_d[i] = faultS[i] | (statusOut[i] & ~clrHere);
		end
	endgenerate

	// Framing flag: a new error wins over a clear in the same cycle
	wire errClr = pinClear | (wrStatus & rxWord[`SPIHB_FRAME_ERR_BIT]);
	assign status_d[`SPIHB_FRAME_ERR_BIT] = frameErr | (statusOut[`SPIHB_FRAME_ERR_BIT] & ~errClr);

	// One register for the whole word keeps a single driver per status bit
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			statusOut <= `SPIHB_STATUS_RST;
			framing_error_flag <= 1'b0;
		end else begin
			statusOut <= status_d;
			framing_error_flag <= status_d[`SPIHB_FRAME_ERR_BIT];
		end
	end
endmodule // spihb_slave

// ==== spihb_props.sv ====
// Purpose: Pin-level checks of the serial slave
// Assumes: 100 MHz core clock, 80 ns sclk
// Notes: Delays allow for the 2-FF pin sync
`timescale 1ns/1ps
module spihb_props (
	// Clock and reset
	input logic core_clk,
	input logic arst_n,
	// Link
	input logic csN,
	input logic sclk,
	input logic miso,
	input logic misoOe,
	// Pins and state
	input logic output_disable_in,
	input logic device_enable_in,
	input logic [10:0] faultActive,
	input logic [11:0] statusOut,
	input logic [12:0] maskOut,
	input logic [12:0] configOut,
	input logic framing_error_flag
);
// ****************
// Checks
// ****************
default clocking @(posedge core_clk); endclocking
default disable iff (!arst_n);
AST_OE_ON: assert property ($fell(csN) |-> ##4 misoOe) else $error("miso not driven");
AST_OE_OFF: assert property ($rose(csN) |-> ##4 !misoOe) else $error("miso not released");
AST_EDGE: assert property (misoOe && $past(misoOe) && $changed(miso) |->
	$past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4)) else $error("miso moved off rise");
AST_LATCH: assert property ($stable(faultActive)[*5] |->
	(statusOut[10:0] & faultActive) == faultActive) else $error("fault not held");
AST_EN_CLR: assert property ((faultActive == 11'h000)[*6] ##0 $rose(device_enable_in)
	|-> ##[1:8] statusOut == 12'h000) else $error("enable rise kept faults");
AST_DISABLE_CLR: assert property ((faultActive == 11'h000)[*6] ##0 $fell(output_disable_in)
	|-> ##[1:8] statusOut == 12'h000) else $error("disable fall kept faults");
AST_REGS: assert property (!csN && !$past(csN) |->
	$stable(maskOut) && $stable(configOut)) else $error("register moved in frame");
AST_FRAME_ERR: assert property ($rose(framing_error_flag) |-> csN && $past(csN, 2))
	else $error("error mid frame");
cover property ($rose(framing_error_flag));
cover property ($fell(statusOut[0]));
cover property ($rose(misoOe) ##[1:200] $changed(miso));
endmodule // spihb_props
bind spihb_slave spihb_props u_spihb_props (.core_clk(core_clk), .arst_n(arst_n), .csN(csN), .sclk(sclk),
	.miso(miso), .misoOe(misoOe), .output_disable_in(output_disable_in), .device_enable_in(device_enable_in),
	.faultActive(faultActive), .statusOut(statusOut), .maskOut(maskOut), .configOut(configOut),
	.framing_error_flag(framing_error_flag));

// ==== spihb_master.sv ====
// Purpose: Serial bus master model for the slave pins
// Assumes: 80 ns sclk, idle low
// Notes: Reads miso just before each rise, where it has settled
`timescale 1ns/1ps
module spihb_master (
	// Link
	output logic csN,
	output logic sclk,
	output logic mosi,
	input wire miso
);
initial begin
	csN = 1'b1;
	sclk = 1'b0;
	mosi = 1'b0;
end
// ****************
// Frame task
// ****************
task automatic xfer(input int n, input logic [47:0] d, output logic [47:0] q);
	q = '0;
	csN = 1'b0;
	// Whole core periods only, so pins never move on a core edge
	#40;
	for (int i = n - 1; i >= 0; i--) begin
		mosi = d[i];
		sclk = 1'b1;
		#40;
		sclk = 1'b0;
		#40;
		q[i] = miso;
	end
	csN = 1'b1;
	mosi = ~mosi;
	#500;
endtask
endmodule // spihb_master

// ==== spihb_slave_bench.sv ====
// Purpose: Self-checking bench for the serial slave
// Assumes: 100 MHz core clock, 80 ns sclk
// Notes: Frames are blocking calls into the master model
`timescale 1ns/1ps
module spihb_slave_bench;
// ****************
// Harness
// ****************
logic core_clk, arst_n, csN, sclk, mosi, miso, misoOe;
logic output_disable_in, device_enable_in, framing_error_flag;
logic [10:0] faultActive;
logic [11:0] statusOut;
logic [12:0] maskOut, configOut;
logic [47:0] got;
wire misoPin = misoOe ? miso : 1'bz;
int n_mismatch = 0;
int samples_checked = 0;
logic [31:0] rows [7] = '{32'hd234_2000, 32'h5fff_5234, 32'hf555_5234, 32'h6000_7555,
	32'h0000_7555, 32'h2000_0000, 32'h4000_2000};
spihb_slave u_spihb_slave (.core_clk(core_clk), .arst_n(arst_n), .csN(csN), .sclk(sclk), .mosi(mosi),
	.miso(miso), .misoOe(misoOe), .output_disable_in(output_disable_in), .device_enable_in(device_enable_in),
	.faultActive(faultActive), .statusOut(statusOut), .maskOut(maskOut), .configOut(configOut),
	.framing_error_flag(framing_error_flag));
spihb_master u_spihb_master (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(misoPin));
initial begin
	core_clk = 1'b0;
	forever #5 core_clk = ~core_clk;
end
task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
	samples_checked++;
	if (g !== e) begin
		n_mismatch++;
		$display("[ERR] %s exp %h got %h", nm, e, g);
	end
endtask
task automatic conclude;
	$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
	if (n_mismatch == 0 && samples_checked > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
// Pins held over 1 us so every clear is guaranteed
task automatic pins(input logic [10:0] f, input logic e, input logic d);
	@(posedge core_clk);
	faultActive <= f;
	device_enable_in <= e;
	output_disable_in <= d;
	repeat (110) @(posedge core_clk);
	// Step off the edge so outputs read next have settled
	#1;
endtask
initial begin
	repeat (20000) @(posedge core_clk);
	n_mismatch++;
	conclude;
end
initial begin
	arst_n = 1'b0;
	faultActive = '0;
	device_enable_in = 1'b1;
	output_disable_in = 1'b0;
	repeat (10) @(posedge core_clk);
	arst_n <= 1'b1;
	repeat (6) @(posedge core_clk);
	#1;
	chk("rst", {13'h06f1, 13'h0d98, 12'h000}, {maskOut, configOut, statusOut});
	foreach (rows[i]) begin
		u_spihb_master.xfer(16, {32'h0, rows[i][31:16]}, got);
		chk("reply", {32'h0, rows[i][15:0]}, got);
	end
	u_spihb_master.xfer(32, 48'h6000_4000, got);
	chk("chain", 48'h5234_6000, got);
	u_spihb_master.xfer(15, 48'h2000, got);
	chk("err15", 1, framing_error_flag);
	u_spihb_master.xfer(16, 48'h2000, got);
	chk("keepSel", 48'h5234, got);
	u_spihb_master.xfer(16, 48'ha800, got);
	chk("clrErr", 0, framing_error_flag);
	u_spihb_master.xfer(16, 48'h8000, got);
	chk("idWrite", 1, framing_error_flag);
	u_spihb_master.xfer(16, 48'ha800, got);
	chk("idSel", 48'h2800, got);
	u_spihb_master.xfer(0, 48'h0, got);
	chk("err0", 1, framing_error_flag);
	pins(11'h003, 1'b1, 1'b0);
	chk("latch", 12'h803, statusOut);
	pins(11'h002, 1'b1, 1'b0);
	chk("hold", 12'h803, statusOut);
	u_spihb_master.xfer(16, 48'ha003, got);
	u_spihb_master.xfer(16, 48'h6000, got);
	chk("stWrite", 48'h2802, got);
	pins(11'h000, 1'b0, 1'b0);
	pins(11'h000, 1'b1, 1'b0);
	chk("enClr", 12'h000, statusOut);
	u_spihb_master.xfer(16, 48'h4000, got);
	chk("enSel", 48'h2000, got);
	pins(11'h010, 1'b1, 1'b0);
	pins(11'h000, 1'b1, 1'b1);
	chk("offRise", 12'h010, statusOut);
	pins(11'h000, 1'b1, 1'b0);
	chk("offClr", 12'h000, statusOut);
	conclude;
end
endmodule // spihb_slave_bench
